// ==== txsp_pkg.sv ====
package txsp_pkg;
   // ==========================================================
   // Frame geometry
   localparam int          BITS_PER_CHANNEL   = 8;
   localparam int          CHANNELS_PER_FRAME = 24;
   localparam logic [2:0]  BIT_LAST           = 3'h7;
   localparam logic [2:0]  BIT_RESET          = 3'h0;
   localparam logic [4:0]  CHAN_LAST          = 5'h17;
   localparam logic [4:0]  CHAN_RESET         = 5'h00;
   // ==========================================================
   // Buffer shape
   localparam int          FIFO_WIDTH         = 8;
   localparam int          FIFO_DEPTH         = 8;
   localparam logic [2:0]  SYNC_RESET         = 3'h0;
   localparam logic [7:0]  BYTE_RESET         = 8'h00;
endpackage : txsp_pkg

// ==== txsp_fifo.sv ====
`timescale 1ns/1ns
// ==========================================================
// Single-clock word FIFO
module txsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              full_w  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire              empty_w = (wr_q == rd_q);
   wire              push_w  = in_valid && !full_w;
   wire              pop_w   = out_ready && !empty_w;

   // Flags and head word
   assign in_ready  = !full_w;
   assign out_valid = !empty_w;
   assign out_data  = mem_q[rd_q[AW-1:0]];

   // Storage write
   always_ff @(posedge clk) begin
      if (push_w) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push_w) wr_q <= wr_q + 1'b1;
         if (pop_w)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule : txsp_fifo

// ==== txsp_bits_if.sv ====
`timescale 1ns/1ns
// ==========================================================
// Byte path from deserialiser to buffer
interface txsp_bits_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : txsp_bits_if

// ==== t1_tx_system_serial_port.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Link side runs on 1.544 MHz line clock, or on system clock with the store enabled; bytes leave this port on core clock
// - Store bypassed: capture serial bit on line-clock fall
// - Store enabled: capture serial bit on system-clock fall
// - Channel clock high during each channel LSB
// - Store bypassed: channel clock follows line clock
// - Store enabled: channel clock follows system clock
// - Frame sync pulse aligns system-side frame
module t1_tx_system_serial_port
   import txsp_pkg::*;
(
   // Core clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Mode strap: transmit elastic store enabled
   input  wire logic       store_enable,
   // Link pins
   input  wire logic       tx_line_clock,
   input  wire logic       tx_system_clock,
   input  wire logic       tx_serial_in,
   input  wire logic       tx_frame_sync_in,
   output logic            tx_channel_clock,
   // Payload bytes to the formatter, core clock
   output logic            byte_valid,
   input  wire logic       byte_ready,
   output logic [7:0]      byte_data,
   output logic            byte_frame_start,
   output logic            overrun
);
   // ==========================================================
   // Link clock domain
   // The active serial clock is picked by the mode strap; it runs the
   // link-side counters and capture on its falling edge, which is where bits are taken.
   wire link_clock_w = store_enable ? tx_system_clock : tx_line_clock;

   logic [2:0] bit_q;
   logic [2:0] bit_d;
   logic [4:0] chan_q;
   logic [4:0] chan_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] word_q;
   logic       word_tgl_q;
   logic       word_first_q;
   logic       chclk_link_q;
   logic       sync_prev_q;
   logic       link_rst_m_q;
   logic       link_rst_q;

   // Reset is brought into the link domain by a two-stage synchroniser
   always_ff @(negedge link_clock_w) begin
      link_rst_m_q <= rst;
      link_rst_q   <= link_rst_m_q;
   end

   // Frame pulse only matters with the store in use; it restarts counting
   wire sync_rise_w = store_enable && tx_frame_sync_in && !sync_prev_q;
   wire last_bit_w  = (bit_q == BIT_LAST);
   wire last_chan_w = (chan_q == CHAN_LAST);

   // Bit and channel counters, frame aligned
   // The bit taken at the sync edge is already bit 0, so the count moves on to 1
   assign bit_d   = sync_rise_w ? (BIT_RESET + 3'h1) : bit_q + 3'h1;
   assign chan_d  = sync_rise_w ? CHAN_RESET
                  : (last_bit_w ? (last_chan_w ? CHAN_RESET : chan_q + 5'h1) : chan_q);
   assign shift_d = {shift_q[6:0], tx_serial_in};                         // MSB first

   always_ff @(negedge link_clock_w) begin
      if (link_rst_q) begin
         bit_q       <= BIT_RESET;
         chan_q      <= CHAN_RESET;
         sync_prev_q <= 1'b0;
      end else begin
         bit_q       <= bit_d;
         chan_q      <= chan_d;
         sync_prev_q <= tx_frame_sync_in;
      end
   end

   // Serial capture on the falling edge of the selected clock
   always_ff @(negedge link_clock_w) begin
      if (link_rst_q) begin
         shift_q <= BYTE_RESET;
      end else begin
         shift_q <= shift_d;
      end
   end

   // Completed channel byte handed over with a toggle
   always_ff @(negedge link_clock_w) begin
      if (link_rst_q) begin
         word_q       <= BYTE_RESET;
         word_tgl_q   <= 1'b0;
         word_first_q <= 1'b0;
      end else if (last_bit_w && !sync_rise_w) begin
         word_q       <= shift_d;
         word_tgl_q   <= ~word_tgl_q;
         word_first_q <= (chan_q == CHAN_RESET);
      end
   end

   // Channel clock: high across the LSB slot, on the rising edge so the
   // pulse spans exactly one bit time of the selected clock.
   always_ff @(posedge link_clock_w) begin
      if (link_rst_q) begin
         chclk_link_q <= 1'b0;
      end else begin
         chclk_link_q <= (bit_q == BIT_LAST);
      end
   end
   assign tx_channel_clock = chclk_link_q;

   // ==========================================================
   // Core clock domain
   // Toggle passes three stages; the event counts when stages two and
   // three differ. Word and flag are stable long before the toggle lands.
   logic [2:0] tgl_sync_q;
   logic       core_valid_q;
   logic [7:0] core_data_q;
   logic       core_first_q;
   logic       overrun_q;
   logic       fifo_ready;
   logic       fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic       first_pend_q;
   // Output register stage so every output comes from a flip-flop
   logic       byte_valid_q;
   logic [7:0] byte_data_q;
   logic       byte_first_q;
   wire        pop_w = fifo_out_valid && byte_ready && !byte_valid_q;

   wire word_event_w = tgl_sync_q[2] ^ tgl_sync_q[1];

   always_ff @(posedge clk) begin
      if (rst) begin
         tgl_sync_q <= SYNC_RESET;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], word_tgl_q};
      end
   end

   // Capture the crossed word as a one-cycle push
   always_ff @(posedge clk) begin
      if (rst) begin
         core_valid_q <= 1'b0;
         core_data_q  <= BYTE_RESET;
         core_first_q <= 1'b0;
      end else begin
         core_valid_q <= word_event_w;
         core_data_q  <= word_event_w ? word_q : core_data_q;
         core_first_q <= word_event_w ? word_first_q : core_first_q;
      end
   end

   // A word arriving with the buffer full is lost; the sticky flag shows it
   always_ff @(posedge clk) begin
      if (rst) begin
         overrun_q <= 1'b0;
      end else if (core_valid_q && !fifo_ready) begin
         overrun_q <= 1'b1;
      end
   end
   assign overrun = overrun_q;

   // Buffer between the serial side and the formatter
   txsp_bits_if bits_if ();
   assign bits_if.valid = core_valid_q;
   assign bits_if.data  = core_data_q;
   assign fifo_ready    = bits_if.ready;

   txsp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (bits_if.valid),
      .in_ready  (bits_if.ready),
      .in_data   (bits_if.data),
      .out_valid (fifo_out_valid),
      .out_ready (byte_ready && !byte_valid_q),
      .out_data  (fifo_out_data)
   );

   // Frame-start marks travel beside the bytes as a pending bit
   always_ff @(posedge clk) begin
      if (rst) begin
         first_pend_q <= 1'b0;
      end else if (core_valid_q && fifo_ready && core_first_q) begin
         first_pend_q <= 1'b1;
      end else if (pop_w) begin
         first_pend_q <= 1'b0;
      end
   end

   // Output byte register; a pop is never taken while valid still stands
   always_ff @(posedge clk) begin
      if (rst) begin
         byte_valid_q <= 1'b0;
         byte_data_q  <= BYTE_RESET;
         byte_first_q <= 1'b0;
      end else begin
         byte_valid_q <= pop_w;
         byte_data_q  <= pop_w ? fifo_out_data : byte_data_q;
         byte_first_q <= pop_w && first_pend_q;
      end
   end
   assign byte_valid       = byte_valid_q;
   assign byte_data        = byte_data_q;
   assign byte_frame_start = byte_first_q;
endmodule : t1_tx_system_serial_port

// ==== txsp_port_assertions.sv ====
`timescale 1ns/1ns
// ==========================================================
// Port checker
module txsp_port_assertions (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_line_clock,
   input wire logic tx_system_clock,
   // Link and byte side
   input wire logic store_enable,
   input wire logic tx_frame_sync_in,
   input wire logic tx_channel_clock,
   input wire logic byte_valid,
   input wire logic byte_frame_start,
   input wire logic overrun
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Seven quiet bit times, then the next LSB marker
   sequence s_gap;
      !tx_channel_clock [*7] ##1 tx_channel_clock;
   endsequence
   property p_valid_gap; byte_valid |=> !byte_valid; endproperty
   property p_start_valid; byte_frame_start |-> byte_valid; endproperty
   // Sync reset must clear outputs even while reset is still held
   property p_reset_idle; disable iff (1'b0) rst |=> !byte_valid && !overrun; endproperty
   property p_line_width;
      @(posedge tx_line_clock) disable iff (rst || store_enable)
      $rose(tx_channel_clock) |=> !tx_channel_clock;
   endproperty
   property p_line_period;
      @(posedge tx_line_clock) disable iff (rst || store_enable) $rose(tx_channel_clock) |=> s_gap;
   endproperty
   property p_sys_period;
      @(posedge tx_system_clock) disable iff (rst || !store_enable)
      $rose(tx_channel_clock) |=> s_gap;
   endproperty
   property p_sys_width;
      @(posedge tx_system_clock) disable iff (rst || !store_enable)
      tx_channel_clock |=> !tx_channel_clock;
   endproperty
   // Frame pulse marks bit 0 of channel 0, so the LSB marker follows
   property p_fsync_align;
      @(posedge tx_system_clock) disable iff (rst || !store_enable)
      $rose(tx_frame_sync_in) |-> ##[6:9] tx_channel_clock;
   endproperty
   a_valid_gap: assert property (p_valid_gap) else $error("byte_valid too long");
   a_start_valid: assert property (p_start_valid) else $error("lone frame start");
   a_reset_idle: assert property (p_reset_idle) else $error("busy in reset");
   a_line_width: assert property (p_line_width) else $error("marker width");
   a_line_period: assert property (p_line_period) else $error("line period");
   a_sys_period: assert property (p_sys_period) else $error("system period");
   a_sys_width: assert property (p_sys_width) else $error("system width");
   a_fsync_align: assert property (p_fsync_align) else $error("frame align");
endmodule : txsp_port_assertions

bind t1_tx_system_serial_port txsp_port_assertions i_chk (.clk(clk), .rst(rst),
   .tx_line_clock(tx_line_clock), .tx_system_clock(tx_system_clock),
   .store_enable(store_enable), .tx_frame_sync_in(tx_frame_sync_in),
   .tx_channel_clock(tx_channel_clock), .byte_valid(byte_valid),
   .byte_frame_start(byte_frame_start), .overrun(overrun));

// ==== t1_backplane_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// Backplane model: counting bytes, MSB first
module t1_backplane_model (
   // Control from bench
   input  wire logic store_enable,
   input  wire logic go,
   // Link pins
   input  wire logic tx_line_clock,
   input  wire logic tx_channel_clock,
   output logic      tx_system_clock,
   output logic      tx_serial_in,
   output logic      tx_frame_sync_in
);
   logic [7:0] cur_q = 8'h00;
   logic [7:0] nxt_q = 8'ha1;
   logic [2:0] idx_q = 3'h0;
   wire logic  sel_clk = store_enable ? tx_system_clock : tx_line_clock;
   // System clock runs only with the store in use, low otherwise
   initial begin
      tx_serial_in = 1'b0;
      tx_frame_sync_in = 1'b0;
      tx_system_clock = 1'b0;
      forever #6 tx_system_clock = store_enable & ~tx_system_clock;
   end
   // Launch on the rise so data is settled at the capturing fall
   always @(posedge sel_clk) begin
      tx_serial_in <= cur_q[3'h7 - idx_q];
      tx_frame_sync_in <= store_enable && cur_q == 8'ha1 && idx_q == 3'h0;
   end
   // Realign on the LSB marker; filler zeros until go
   always @(negedge sel_clk) begin
      if (tx_channel_clock) begin
         idx_q <= 3'h0;
         cur_q <= go ? nxt_q : 8'h00;
         nxt_q <= go ? nxt_q + 8'h01 : 8'ha1;
      end else begin
         idx_q <= idx_q + 3'h1;
      end
   end
endmodule : t1_backplane_model

// ==== t1_tx_system_serial_port_test.sv ====
`timescale 1ns/1ns
// ==========================================================
// Bench top
module t1_tx_system_serial_port_test;
   logic       clk, rst, store_enable, byte_ready, go, tx_line_clock;
   wire logic  tx_system_clock, tx_serial_in, tx_frame_sync_in, tx_channel_clock;
   wire logic  byte_valid, byte_frame_start, overrun;
   wire logic [7:0] byte_data;
   logic [8:0] seen_q[$];
   int         err_count = 0;
   int         n_tests = 0;
   // Core clock, and a free line clock of unrelated phase
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      tx_line_clock = 1'b0;
      #3;
      forever #6 tx_line_clock = ~tx_line_clock;
   end
   t1_tx_system_serial_port i_dut (.clk(clk), .rst(rst), .store_enable(store_enable),
      .tx_line_clock(tx_line_clock), .tx_system_clock(tx_system_clock),
      .tx_serial_in(tx_serial_in), .tx_frame_sync_in(tx_frame_sync_in),
      .tx_channel_clock(tx_channel_clock), .byte_valid(byte_valid), .byte_ready(byte_ready),
      .byte_data(byte_data), .byte_frame_start(byte_frame_start), .overrun(overrun));
   t1_backplane_model i_far (.store_enable(store_enable), .go(go),
      .tx_line_clock(tx_line_clock), .tx_channel_clock(tx_channel_clock),
      .tx_system_clock(tx_system_clock), .tx_serial_in(tx_serial_in),
      .tx_frame_sync_in(tx_frame_sync_in));
   // Byte monitor; valid stands for one cycle only
   always @(negedge clk) if (byte_valid === 1'b1) seen_q.push_back({byte_frame_start, byte_data});
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic wait_bytes(input int n);
      for (int i = 0; i < 400 && seen_q.size() < n; i++) @(negedge clk);
      if (seen_q.size() < n) begin
         err_count++;
         $display("[FAIL] bytes expected %0d seen %0d", n, seen_q.size());
         end_sim();
      end
   endtask : wait_bytes
   // Long reset covers the link-side synchroniser too
   task automatic do_reset(input logic se);
      rst = 1'b1;
      store_enable = se;
      go = 1'b0;
      byte_ready = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (40) @(negedge clk);
      seen_q.delete();
   endtask : do_reset
   task automatic t_stream(input logic se);
      do_reset(se);
      go = 1'b1;
      wait_bytes(10);
      go = 1'b0;
      while (seen_q.size() > 0 && seen_q[0][7:0] == 8'h00) void'(seen_q.pop_front());
      for (int k = 0; k < 4; k++)
         check("byte", {se & (k == 0), 8'ha1 + 8'(k)}, {se & seen_q[k][8], seen_q[k][7:0]});
      $display("test stream store=%0b done", se);
   endtask : t_stream
   // Stall the sink so the buffer fills, refuses, then drains
   task automatic t_stall;
      do_reset(1'b0);
      byte_ready = 1'b0;
      repeat (200) @(negedge clk);
      check("held", 9'h000, 9'(seen_q.size()));
      check("overrun", 9'h001, {8'h00, overrun});
      byte_ready = 1'b1;
      wait_bytes(8);
      do_reset(1'b0);
      check("overrun clear", 9'h000, {8'h00, overrun});
      $display("test stall done");
   endtask : t_stall
   initial begin
      rst = 1'b1;
      store_enable = 1'b0;
      byte_ready = 1'b0;
      go = 1'b0;
      @(negedge clk);
      t_stream(1'b0);
      t_stream(1'b1);
      t_stall();
      end_sim();
   end
endmodule : t1_tx_system_serial_port_test
